// >>> src/mcu_ctl_pkg.sv
// Constants for the reset, interrupt and port control block.
// Assumes one 100 MHz clock and a synchronous active-high reset.
package mcu_ctl_pkg;
   localparam logic [15:0] PORT1_DIRECTION_OFS = 16'h0000;
   localparam logic [15:0] PORT2_DIRECTION_OFS = 16'h0001;
   localparam logic [15:0] PORT1_DATA_OFS = 16'h0002;
   localparam logic [15:0] PORT2_DATA_OFS = 16'h0003;
   localparam logic [15:0] PORT3_DIRECTION_OFS = 16'h0004;
   localparam logic [15:0] PORT4_DIRECTION_OFS = 16'h0005;
   localparam logic [15:0] PORT3_DATA_OFS = 16'h0006;
   localparam logic [15:0] PORT4_DATA_OFS = 16'h0007;
   localparam logic [15:0] PORT3_CTRL_OFS = 16'h000f;
   // Port 3 control bits
   localparam int P3C_FLAG_BIT = 7;
   localparam int P3C_IEN_BIT = 6;
   localparam int P3C_OSS_BIT = 4;
   localparam int P3C_LATCH_BIT = 3;
   // Vectors, high byte address
   localparam logic [15:0] VEC_RESET = 16'hfffe;
   localparam logic [15:0] VEC_NMI = 16'hfffc;
   localparam logic [15:0] VEC_SWI = 16'hfffa;
   localparam logic [15:0] VEC_EXT = 16'hfff8;
   localparam logic [15:0] VEC_CAPTURE = 16'hfff6;
   localparam logic [15:0] VEC_COMPARE = 16'hfff4;
   localparam logic [15:0] VEC_WRAP = 16'hfff2;
   localparam logic [15:0] VEC_SERIAL = 16'hfff0;
   localparam logic [15:0] IO_WINDOW_BASE = 16'h0100;
   localparam logic [7:0] RESET_VAL = 8'h00;
   localparam logic [1:0] BUS_DIV = 2'h3;
   localparam int RESET_MIN_CYC = 3;
   typedef enum logic [1:0] {MODE_SINGLE, MODE_MUX, MODE_NONMUX} mode_t;
endpackage

// >>> src/mcu_reset_irq_port_control.sv
// Reset release, interrupt vector selection, port registers and bus strobes.
// Assumes clk is the crystal clock, all pins synchronous to it, and a
// core that requests register accesses and reports instruction boundaries.
`timescale 1ns/100ps
module mcu_reset_irq_port_control
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   input wire logic power_on_init_input_n,
   // Core register access
   input wire logic acc_valid,
   input wire logic acc_write,
   input wire logic [15:0] acc_addr,
   input wire logic [7:0] acc_wdata,
   output logic [7:0] acc_rdata,
   output logic acc_internal,
   // Core sequencing
   input wire logic instr_done,
   input wire logic mask_clear,
   input wire logic software_trap,
   input wire logic capture_event,
   input wire logic compare_event,
   input wire logic counter_wrap_event,
   input wire logic serial_port,
   output logic core_hold,
   output logic int_start,
   output logic [15:0] vector_addr,
   output logic stack_regs,
   output logic int_mask,
   output logic [2:0] mode_bits,
   // Interrupt pins
   input wire logic nmi_n,
   input wire logic external_int_line_n,
   // Bus control
   output logic bus_clk,
   output logic read_write,
   output logic io_window_select_n,
   output logic addr_latch_strobe,
   output logic upper_addr_force,
   output logic port3_addr_drive,
   // Port 3 strobes
   input wire logic port3_input_strobe_n,
   output logic port3_output_strobe_n,
   // Port pins
   input wire logic [7:0] port1_in,
   output logic [7:0] port1_out,
   output logic [7:0] port1_oe,
   input wire logic [4:0] port2_in,
   output logic [4:0] port2_out,
   output logic [4:0] port2_oe,
   input wire logic [7:0] port3_in,
   output logic [7:0] port3_out,
   output logic [7:0] port3_oe,
   input wire logic [7:0] port4_in,
   output logic [7:0] port4_out,
   output logic [7:0] port4_oe
);
   typedef struct packed {
      logic [1:0] div;
      logic init_prev;
      logic nmi_prev;
      logic nmi_pend;
      logic is3_prev;
      logic boot;
      logic mask;
      logic [2:0] mode;
      logic [7:0] p1_dir;
      logic [7:0] p2_dir;
      logic [7:0] p3_dir;
      logic [7:0] p4_dir;
      logic [7:0] p1_dat;
      logic [4:0] p2_dat;
      logic [7:0] p3_dat;
      logic [7:0] p4_dat;
      logic [7:0] p3_latch;
      logic latched;
      logic flag;
      logic flag_armed;
      logic ien;
      logic oss;
      logic latch_en;
      logic os3;
      logic int_go;
      logic stack;
      logic [15:0] vec;
      logic [7:0] rdata;
   } state_t;

   state_t s_q, s_d;
   mcu_ctl_pkg::mode_t mode_now;

   // Mode pins map to the three bus arrangements; unlisted codes single chip
   function automatic mcu_ctl_pkg::mode_t decode_mode(input logic [2:0] m);
      case (m)
         3'h4: decode_mode = mcu_ctl_pkg::MODE_MUX;
         3'h5: decode_mode = mcu_ctl_pkg::MODE_NONMUX;
         3'h6: decode_mode = mcu_ctl_pkg::MODE_MUX;
         default: decode_mode = mcu_ctl_pkg::MODE_SINGLE;
      endcase
   endfunction

   function automatic logic is_reg(input logic [15:0] a, input logic [15:0] ofs);
      is_reg = (a == ofs);
   endfunction

   logic phase_end;
   logic rd, wr;
   logic p3_access;
   logic ext_req, int_req;

   always_comb
   begin
      s_d = s_q;
      mode_now = decode_mode(s_q.mode);
      phase_end = (s_q.div == mcu_ctl_pkg::BUS_DIV);
      rd = acc_valid && !acc_write;
      wr = acc_valid && acc_write;
      p3_access = acc_valid && is_reg(acc_addr, mcu_ctl_pkg::PORT3_DATA_OFS);
      s_d.div = s_q.div + 2'h1;
      s_d.init_prev = power_on_init_input_n;
      s_d.nmi_prev = nmi_n;
      s_d.is3_prev = port3_input_strobe_n;
      s_d.int_go = 1'b0;
      s_d.stack = 1'b0;
      s_d.os3 = 1'b1;
      // Reset pin low: hold the core; pulse length is the source's duty
      if (power_on_init_input_n && !s_q.init_prev)
      begin
         s_d.mode = port2_in[2:0];
         s_d.boot = 1'b1;
         s_d.mask = 1'b1;
      end
      // Falling edge is remembered until an instruction boundary
      if (s_q.nmi_prev && !nmi_n)
         s_d.nmi_pend = 1'b1;
      ext_req = !external_int_line_n;
      int_req = capture_event | compare_event | counter_wrap_event | serial_port
         | (s_q.flag && s_q.ien);
      if (mask_clear)
         s_d.mask = 1'b0;
      // Sampled at end of the bus phase; start-up fetch at once, others at a finished instruction
      if (phase_end && power_on_init_input_n)
      begin
         if (s_q.boot)
         begin
            s_d.boot = 1'b0;
            s_d.int_go = 1'b1;
            s_d.vec = mcu_ctl_pkg::VEC_RESET;
         end
         else if (instr_done)
         begin
            // Priority order, highest first
            if (s_q.nmi_pend || (s_q.nmi_prev && !nmi_n))
            begin
               s_d.nmi_pend = 1'b0;
               s_d.int_go = 1'b1;
               s_d.stack = 1'b1;
               s_d.vec = mcu_ctl_pkg::VEC_NMI;
            end
            else if (software_trap)
            begin
               s_d.int_go = 1'b1;
               s_d.stack = 1'b1;
               s_d.mask = 1'b1;
               s_d.vec = mcu_ctl_pkg::VEC_SWI;
            end
            else if (!s_q.mask && (ext_req || (s_q.flag && s_q.ien)))
            begin
               s_d.int_go = 1'b1;
               s_d.stack = 1'b1;
               s_d.mask = 1'b1;
               s_d.vec = mcu_ctl_pkg::VEC_EXT;
            end
            else if (!s_q.mask && int_req)
            begin
               s_d.int_go = 1'b1;
               s_d.stack = 1'b1;
               s_d.mask = 1'b1;
               if (capture_event)
                  s_d.vec = mcu_ctl_pkg::VEC_CAPTURE;
               else if (compare_event)
                  s_d.vec = mcu_ctl_pkg::VEC_COMPARE;
               else if (counter_wrap_event)
                  s_d.vec = mcu_ctl_pkg::VEC_WRAP;
               else
                  s_d.vec = mcu_ctl_pkg::VEC_SERIAL;
            end
         end
      end
      // Register writes
      if (wr)
      begin
         if (is_reg(acc_addr, mcu_ctl_pkg::PORT1_DIRECTION_OFS))
            s_d.p1_dir = acc_wdata;
         if (is_reg(acc_addr, mcu_ctl_pkg::PORT2_DIRECTION_OFS))
            s_d.p2_dir = acc_wdata;
         if (is_reg(acc_addr, mcu_ctl_pkg::PORT3_DIRECTION_OFS))
            s_d.p3_dir = acc_wdata;
         if (is_reg(acc_addr, mcu_ctl_pkg::PORT4_DIRECTION_OFS))
            s_d.p4_dir = acc_wdata;
         if (is_reg(acc_addr, mcu_ctl_pkg::PORT1_DATA_OFS))
            s_d.p1_dat = acc_wdata;
         if (is_reg(acc_addr, mcu_ctl_pkg::PORT2_DATA_OFS))
            s_d.p2_dat = acc_wdata[4:0];
         if (is_reg(acc_addr, mcu_ctl_pkg::PORT3_DATA_OFS))
            s_d.p3_dat = acc_wdata;
         if (is_reg(acc_addr, mcu_ctl_pkg::PORT4_DATA_OFS))
            s_d.p4_dat = acc_wdata;
         if (is_reg(acc_addr, mcu_ctl_pkg::PORT3_CTRL_OFS))
         begin
            s_d.ien = acc_wdata[mcu_ctl_pkg::P3C_IEN_BIT];
            s_d.oss = acc_wdata[mcu_ctl_pkg::P3C_OSS_BIT];
            s_d.latch_en = acc_wdata[mcu_ctl_pkg::P3C_LATCH_BIT];
         end
      end
      // Register reads; direction registers read as zero
      s_d.rdata = 8'h00;
      if (rd)
      begin
         if (is_reg(acc_addr, mcu_ctl_pkg::PORT1_DATA_OFS))
            s_d.rdata = (s_q.p1_dat & s_q.p1_dir) | (port1_in & ~s_q.p1_dir);
         if (is_reg(acc_addr, mcu_ctl_pkg::PORT2_DATA_OFS))
            s_d.rdata = {s_q.mode, (s_q.p2_dat & s_q.p2_dir[4:0])
               | (port2_in & ~s_q.p2_dir[4:0])};
         if (is_reg(acc_addr, mcu_ctl_pkg::PORT3_DATA_OFS))
            s_d.rdata = (s_q.p3_dat & s_q.p3_dir)
               | ((s_q.latched ? s_q.p3_latch : port3_in) & ~s_q.p3_dir);
         if (is_reg(acc_addr, mcu_ctl_pkg::PORT4_DATA_OFS))
            s_d.rdata = (s_q.p4_dat & s_q.p4_dir) | (port4_in & ~s_q.p4_dir);
         if (is_reg(acc_addr, mcu_ctl_pkg::PORT3_CTRL_OFS))
         begin
            s_d.rdata = {s_q.flag, s_q.ien, 1'b0, s_q.oss, s_q.latch_en, 3'h0};
            s_d.flag_armed = s_q.flag;
         end
      end
      // Port 3 read reopens the latch; any port 3 access completes a flag clear
      if (p3_access)
      begin
         if (rd)
            s_d.latched = 1'b0;
         if (s_q.flag_armed)
         begin
            s_d.flag = 1'b0;
            s_d.flag_armed = 1'b0;
         end
         if (mode_now == mcu_ctl_pkg::MODE_SINGLE && (acc_write == s_q.oss))
            s_d.os3 = 1'b0;
      end
      // Strobe fall sets the flag after the port 3 access clear so the event wins; pin reset below still clears it
      if (mode_now == mcu_ctl_pkg::MODE_SINGLE && s_q.is3_prev && !port3_input_strobe_n)
      begin
         s_d.flag = 1'b1;
         if (s_q.latch_en && !s_q.latched)
         begin
            s_d.p3_latch = port3_in;
            s_d.latched = 1'b1;
         end
      end
      if (!power_on_init_input_n)
      begin
         // Pin reset acts like srst for control state
         s_d.p1_dir = mcu_ctl_pkg::RESET_VAL;
         s_d.p2_dir = mcu_ctl_pkg::RESET_VAL;
         s_d.p3_dir = mcu_ctl_pkg::RESET_VAL;
         s_d.p4_dir = mcu_ctl_pkg::RESET_VAL;
         s_d.flag = 1'b0;
         s_d.flag_armed = 1'b0;
         s_d.ien = 1'b0;
         s_d.latch_en = 1'b0;
         s_d.latched = 1'b0;
         s_d.oss = 1'b0;
         s_d.nmi_pend = 1'b0;
         s_d.mask = 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         s_q <= '0;
         s_q.init_prev <= 1'b1;
         s_q.nmi_prev <= 1'b1;
         s_q.is3_prev <= 1'b1;
         s_q.mask <= 1'b1;
         s_q.boot <= 1'b1;
         s_q.os3 <= 1'b1;
      end
      else
         s_q <= s_d;
   end

   // Outputs
   assign bus_clk = s_q.div[1];
   assign core_hold = !power_on_init_input_n || s_q.boot;
   assign upper_addr_force = !power_on_init_input_n || s_q.boot;
   assign int_start = s_q.int_go;
   assign stack_regs = s_q.stack;
   assign vector_addr = s_q.vec;
   assign int_mask = s_q.mask;
   assign mode_bits = s_q.mode;
   assign acc_rdata = s_q.rdata;
   assign acc_internal = acc_valid && (acc_addr[15:3] == 13'h0000
      || is_reg(acc_addr, mcu_ctl_pkg::PORT3_CTRL_OFS));
   assign port3_output_strobe_n = s_q.os3;
   // Direction line rests high outside transfers
   assign read_write = !(acc_valid && acc_write
      && mode_now != mcu_ctl_pkg::MODE_SINGLE);
   assign io_window_select_n = !(mode_now == mcu_ctl_pkg::MODE_NONMUX && acc_valid
      && acc_addr[15:8] == mcu_ctl_pkg::IO_WINDOW_BASE[15:8]);
   // Strobe in the first half of the bus cycle, address off in the second
   assign addr_latch_strobe = mode_now == mcu_ctl_pkg::MODE_MUX && acc_valid
      && !s_q.div[1];
   assign port3_addr_drive = addr_latch_strobe;
   assign port1_out = s_q.p1_dat;
   assign port1_oe = s_q.p1_dir;
   assign port2_out = s_q.p2_dat;
   assign port2_oe = s_q.p2_dir[4:0];
   assign port3_out = s_q.p3_dat;
   assign port3_oe = s_q.p3_dir;
   assign port4_out = s_q.p4_dat;
   assign port4_oe = s_q.p4_dir;
endmodule

// >>> dv/mcu_ctl_props.sv
// Pin-level checker for the control block.
// One clock; srst disables every property.
`timescale 1ns/100ps
module mcu_ctl_props
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   input wire logic power_on_init_input_n,
   // Core side
   input wire logic acc_valid,
   input wire logic acc_write,
   input wire logic [15:0] acc_addr,
   input wire logic instr_done,
   input wire logic [4:0] port2_in,
   input wire logic [2:0] mode_bits,
   input wire logic core_hold,
   input wire logic int_start,
   input wire logic [15:0] vector_addr,
   input wire logic int_mask,
   input wire logic stack_regs,
   // Pins
   input wire logic bus_clk,
   input wire logic read_write,
   input wire logic io_window_select_n,
   input wire logic upper_addr_force,
   input wire logic port3_output_strobe_n,
   input wire logic [7:0] port1_oe,
   input wire logic [4:0] port2_oe
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   // Four low samples ride out any pin synchroniser
   sequence s_pin_low;
      (!power_on_init_input_n) [*4];
   endsequence
   sequence s_bus_period;
      bus_clk [*2] ##1 (!bus_clk) [*2] ##1 bus_clk;
   endsequence
   a_bus_clk_div: assert property ($rose(bus_clk) |-> s_bus_period)
      else $error("bus clock period wrong");
   a_upper_force: assert property (s_pin_low |-> upper_addr_force && core_hold)
      else $error("upper address not forced in reset");
   a_mask_reset: assert property (s_pin_low |-> int_mask)
      else $error("mask clear in reset");
   a_ports_input: assert property (s_pin_low |-> port1_oe == 8'h00 && port2_oe == 5'h00)
      else $error("port driven in reset");
   a_mode_latch: assert property ($rose(power_on_init_input_n)
      |-> ##[1:4] (mode_bits == port2_in[2:0]))
      else $error("mode not latched");
   a_reset_vec: assert property ($rose(power_on_init_input_n)
      |-> ##[1:12] (int_start && vector_addr == 16'hfffe))
      else $error("no start vector");
   a_rw_idle: assert property (!(acc_valid && acc_write) |-> read_write)
      else $error("read_write low without write");
   a_io_window: assert property (acc_valid |-> io_window_select_n
      == !(mode_bits == 3'h5 && acc_addr[15:8] == 8'h01))
      else $error("window select wrong");
   a_mask_entry: assert property (int_start && vector_addr inside {[16'hfff0:16'hfff9]}
      |-> !$past(int_mask) ##[0:1] int_mask)
      else $error("maskable entry wrong");
   a_int_boundary: assert property (int_start && vector_addr != 16'hfffe
      |-> $past(instr_done))
      else $error("entry off a boundary");
   a_os3_pulse: assert property ($fell(port3_output_strobe_n) |=> port3_output_strobe_n)
      else $error("output strobe too long");
   // Start-up fetch stacks nothing; every other entry stacks
   a_stack_entry: assert property (int_start |-> stack_regs == (vector_addr != 16'hfffe))
      else $error("stacking wrong on entry");
endmodule
bind mcu_reset_irq_port_control mcu_ctl_props mcu_ctl_props_inst (
   .clk(clk), .srst(srst), .power_on_init_input_n(power_on_init_input_n),
   .acc_valid(acc_valid), .acc_write(acc_write), .acc_addr(acc_addr),
   .instr_done(instr_done), .port2_in(port2_in), .mode_bits(mode_bits),
   .core_hold(core_hold), .int_start(int_start), .vector_addr(vector_addr),
   .int_mask(int_mask), .stack_regs(stack_regs), .bus_clk(bus_clk), .read_write(read_write),
   .io_window_select_n(io_window_select_n), .upper_addr_force(upper_addr_force),
   .port3_output_strobe_n(port3_output_strobe_n), .port1_oe(port1_oe), .port2_oe(port2_oe));

// >>> dv/ext_side.sv
// Far side: reset source and mode wiring on port 2.
// Power-up hold is scaled down through HOLD_CYC.
`timescale 1ns/100ps
module ext_side
#(
   parameter int HOLD_CYC = 3
)
(
   // Clock and request
   input wire logic clk,
   input wire logic rst_req,
   input wire logic [2:0] mode,
   // Pins
   output logic pin_n,
   output logic [4:0] p2
);
   int cnt = HOLD_CYC + 6;
   always @(posedge clk)
      if (rst_req)
         cnt <= HOLD_CYC + 6;
      else if (cnt > 0)
         cnt <= cnt - 1;
   assign pin_n = !(cnt > 6);
   // Released lines flip, so a stale latch cannot pass
   assign p2 = (cnt > 0) ? {2'h0, mode} : {2'h3, ~mode};
endmodule

// >>> dv/testbench.sv
// Bench for the control block; plays the core directly.
// ext_side drives the reset pin and the mode lines.
`timescale 1ns/100ps
module testbench;
   logic clk = 1'b0, srst = 1'b1, rst_req = 1'b0, acc_valid = 1'b0, acc_write = 1'b0;
   logic mask_clear = 1'b0, strobe_n = 1'b1, pin_n, int_start, int_mask, rw, win_n, als, os3_n;
   logic rw_s, win_s;
   logic instr_done = 1'b1;
   logic [2:0] mode = 3'h0, mode_bits;
   logic [4:0] p2, p2_oe;
   logic [6:0] src = 7'h00;
   logic [7:0] acc_wdata = 8'h00, p3_in = 8'h00, acc_rdata, rdata, p1_oe, p1_out, p4_oe;
   logic [15:0] acc_addr = 16'h0000, vector_addr;
   int failures = 0, samples_checked = 0;
   mcu_reset_irq_port_control mcu_reset_irq_port_control_inst (
      .clk(clk), .srst(srst), .power_on_init_input_n(pin_n), .acc_valid(acc_valid),
      .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
      .acc_rdata(acc_rdata), .acc_internal(), .instr_done(instr_done), .mask_clear(mask_clear),
      .software_trap(src[1]), .capture_event(src[3]), .compare_event(src[4]),
      .counter_wrap_event(src[5]), .serial_port(src[6]), .core_hold(),
      .int_start(int_start), .vector_addr(vector_addr), .stack_regs(), .int_mask(int_mask),
      .mode_bits(mode_bits), .nmi_n(!src[0]), .external_int_line_n(!src[2]), .bus_clk(),
      .read_write(rw), .io_window_select_n(win_n), .addr_latch_strobe(als),
      .upper_addr_force(), .port3_addr_drive(), .port3_input_strobe_n(strobe_n),
      .port3_output_strobe_n(os3_n), .port1_in(8'h3c), .port1_out(p1_out), .port1_oe(p1_oe),
      .port2_in(p2), .port2_out(), .port2_oe(p2_oe), .port3_in(p3_in), .port3_out(),
      .port3_oe(), .port4_in(8'hc3), .port4_out(), .port4_oe(p4_oe));
   ext_side #(.HOLD_CYC(40)) ext_side_inst (.clk(clk), .rst_req(rst_req), .mode(mode),
      .pin_n(pin_n), .p2(p2));
   initial forever #5 clk = ~clk;
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
      samples_checked++;
      if (s !== e)
      begin
         failures++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic stop_test();
      $display("failures %0d samples_checked %0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic wait_int(input logic [15:0] v);
      for (int i = 0; i < 100 && int_start !== 1'b1; i++)
         @(posedge clk) #1;
      chk("vector", v, int_start === 1'b1 ? vector_addr : 16'hxxxx);
      if (int_start !== 1'b1)
         stop_test();
   endtask
   task automatic acc(input logic we, input logic [15:0] a, input logic [7:0] wd);
      @(posedge clk);
      acc_valid <= 1'b1;
      acc_write <= we;
      acc_addr <= a;
      acc_wdata <= wd;
      @(negedge clk);
      rw_s = rw;
      win_s = win_n;
      @(posedge clk);
      acc_valid <= 1'b0;
      #1 rdata = acc_rdata;
   endtask
   task automatic pulse_clear();
      @(posedge clk);
      mask_clear <= 1'b1;
      @(posedge clk);
      mask_clear <= 1'b0;
   endtask
   task automatic t_reset(input logic [2:0] m);
      @(posedge clk);
      mode <= m;
      rst_req <= 1'b1;
      @(posedge clk);
      rst_req <= 1'b0;
      wait_int(16'hfffe);
      chk("mode", 16'(m), 16'(mode_bits));
      chk("mask", 16'h1, 16'(int_mask));
      chk("oe", 16'h0, {3'h0, p2_oe, p1_oe});
      acc(1'b1, 16'h0003, 8'hff);
      acc(1'b0, 16'h0003, 8'h00);
      chk("port2 mode", 16'(m), 16'(rdata[7:5]));
   endtask
   task automatic t_regs();
      acc(1'b1, 16'h0000, 8'hff);
      acc(1'b1, 16'h0001, 8'h1f);
      acc(1'b1, 16'h0005, 8'hf0);
      acc(1'b1, 16'h0002, 8'h5a);
      chk("oe", 16'hff1f, {p1_oe, 3'h0, p2_oe});
      chk("port4 oe", 16'h00f0, 16'(p4_oe));
      chk("port1 out", 16'h005a, 16'(p1_out));
      acc(1'b0, 16'h0000, 8'h00);
      chk("direction read", 16'h0, 16'(rdata));
      acc(1'b0, 16'h0008, 8'h00);
      chk("unmapped read", 16'h0, 16'(rdata));
      $display("register test done");
   endtask
   task automatic t_bus();
      logic [15:0] ba [4] = '{16'h0100, 16'h01ff, 16'h0200, 16'h0300};
      int n = 0;
      t_reset(3'h5);
      for (int i = 0; i < 4; i++)
      begin
         acc(!i[0], ba[i], 8'h00);
         chk("read_write", 16'(i[0]), 16'(rw_s));
         chk("io window", 16'(i >= 2), 16'(win_s));
      end
      chk("idle read_write", 16'h1, 16'(rw));
      t_reset(3'h4);
      @(posedge clk);
      acc_valid <= 1'b1;
      acc_write <= 1'b0;
      repeat (4) @(negedge clk) n += int'(als === 1'b1);
      @(posedge clk);
      acc_valid <= 1'b0;
      chk("addr strobe", 16'h1, 16'(n > 0));
      $display("bus test done");
   endtask
   task automatic t_prio();
      int n = 0;
      t_reset(3'h0);
      for (int k = 0; k < 7; k++)
      begin
         pulse_clear();
         src <= 7'(7'h7f << k);
         wait_int(16'(16'hfffc - 2 * k));
         @(posedge clk);
         src <= 7'h00;
      end
      @(posedge clk);
      src <= 7'h04;
      #1 chk("mask set", 16'h1, 16'(int_mask));
      // Masked line held low must not enter
      repeat (30) @(posedge clk) #1 n += int'(int_start === 1'b1);
      chk("masked entries", 16'h0, 16'(n));
      // Unmasked but mid-instruction: entry must wait for the boundary
      instr_done <= 1'b0;
      pulse_clear();
      n = 0;
      repeat (20) @(posedge clk) #1 n += int'(int_start === 1'b1);
      chk("entries off boundary", 16'h0, 16'(n));
      @(posedge clk);
      instr_done <= 1'b1;
      wait_int(16'hfff8);
      @(posedge clk);
      src <= 7'h00;
      $display("priority test done");
   endtask
   task automatic t_strobe();
      acc(1'b1, 16'h000f, 8'h58);
      p3_in <= 8'ha5;
      @(posedge clk);
      strobe_n <= 1'b0;
      repeat (3) @(posedge clk);
      strobe_n <= 1'b1;
      repeat (4) @(posedge clk);
      p3_in <= 8'h5a;
      acc(1'b0, 16'h0006, 8'h00);
      chk("port3 latch", 16'h00a5, 16'(rdata));
      pulse_clear();
      wait_int(16'hfff8);
      acc(1'b1, 16'h0006, 8'h11);
      for (int i = 0; i < 8 && os3_n !== 1'b0; i++)
         @(posedge clk) #1;
      chk("output strobe", 16'h0, 16'(os3_n));
      $display("strobe test done");
   endtask
   initial
   begin
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      wait_int(16'hfffe);
      t_regs();
      t_bus();
      t_prio();
      t_strobe();
      stop_test();
   end
endmodule
